// ===== verilog/peil_pkg.sv
// Constants, types and register layout of the event and interrupt logic.
// Assumes one quad register set per host address; the serial front end lies outside.
//
// Overview of operation
// R1: Host accesses anytime; device only raises attention.
// R2: Events set bits that feed summary bits.
// R3: Attention active when summary and mask agree.
// R4: Host reads summaries first, then event registers.
// R5: Disconnect summary gathers unplug and shed-pin events.
// R6: Disconnect summary clears after both clearing reads.
// R7: Attention released when no enabled summary remains.
// R8: Either quad holds attention asserted.
// R9: Late events stay pending; set beats clear.
// R10: Turn-on failure sets launch fault; both reads.
// R11: Summary and mask share one bit order.
// R12: Rail alarm register layout, bit 7 downward.
// R13: Strap selects budget code or hosted operation.
// R14: Strap mode programs both quads with defaults.
// R15: Strap mode loads identity port mapping.
// R16: Strap mode loads fault-enabling mask.
// R17: Strap mode sets automatic mode, all enables.
// R18: Automatic mode turns classification into power request.
// R19: View reads keep bits; take reads clear returned.
package peil_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_SUMMARY = 8'h00;  // irq_summary
  localparam logic [7:0] OFS_ENABLE  = 8'h01;  // irq_enable_bits
  // Read-only view offsets, index order matches the event indices below
  localparam logic [5:0][7:0] OFS_VIEW = {8'h24, 8'h0A, 8'h08, 8'h06, 8'h04, 8'h02};
  // Clear-on-read offsets, one above each view
  localparam logic [5:0][7:0] OFS_TAKE = {8'h25, 8'h0B, 8'h09, 8'h07, 8'h05, 8'h03};

  // ==========================================================================
  // Event register indices
  localparam int EVI_PWR  = 0;  // Power transitions
  localparam int EVI_PRB  = 1;  // Detection and classification done
  localparam int EVI_UNP  = 2;  // Unplug and two-pair overpower
  localparam int EVI_LIM  = 3;  // Current limit and launch fault
  localparam int EVI_RAIL = 4;  // Supply alarms
  localparam int EVI_TURN = 5;  // Turn-on failures
  localparam int EV_COUNT = 6;

  // ==========================================================================
  // Summary and mask bit positions
  localparam int SUM_SUPPLY  = 7;
  localparam int SUM_START   = 6;
  localparam int SUM_PIFAULT = 5;
  localparam int SUM_CLASS   = 4;
  localparam int SUM_DETECT  = 3;
  localparam int SUM_DISC    = 2;
  localparam int SUM_PGOOD   = 1;
  localparam int SUM_PEN     = 0;

  // Rail alarm register fields
  localparam int RAIL_OVERTEMP = 7;  // Over-temperature
  localparam int RAIL_LFAIL    = 6;  // logic_rail_low_fail
  localparam int RAIL_LWARN    = 5;  // logic_rail_low_warn
  localparam int RAIL_MAIN     = 4;  // main_rail_low
  localparam int RAIL_QP_HI    = 3;  // quadpair_overpower_fault upper bit
  localparam int RAIL_QP_LO    = 2;  // quadpair_overpower_fault lower bit
  localparam int RAIL_SHED     = 1;  // shed_pin_event
  localparam logic [7:0] RAIL_USED = 8'hFE;  // Bit 0 reserved, reads zero

  // ==========================================================================
  // Reset and strap default values
  localparam logic [7:0] ENABLE_RST   = 8'h00;  // Hosted mode mask
  localparam logic [7:0] AUTO_ENABLE  = 8'hE4;  // Fault summaries enabled
  localparam logic [7:0] AUTO_MAPPING = 8'hE4;  // Identity port mapping
  localparam logic [7:0] AUTO_MODE    = 8'hFF;  // All ports automatic
  localparam logic [7:0] AUTO_DETCLS  = 8'hFF;  // All detect and class enables
  localparam logic [7:0] HOST_DEFAULT = 8'h00;  // Hosted values of the above
  localparam logic [2:0] STRAP_NONE   = 3'h0;   // Lower resistor unpopulated
  // Budget code indexed by strap selection, entry 0 unused
  localparam logic [7:0][7:0] AUTO_BUDGET = {8'hFF, 8'hEE, 8'hDD, 8'hCC,
                                             8'hBB, 8'h33, 8'h00, 8'h00};

  // ==========================================================================
  // Types
  typedef struct packed {
    logic       rd;     // Read strobe, one cycle
    logic       wr;     // Write strobe, one cycle
    logic       quad;   // Quad selected by host address
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } peil_req_s;

  typedef struct packed {
    logic [7:0] turnon;  // port_turnon_failure, two bits per port
    logic [7:0] rail;    // Supply alarm set pulses
    logic [7:0] limit;   // [7:4] current limit, [3:0] port_launch_fault
    logic [7:0] unplug;  // [7:4] two-pair overpower, [3:0] disconnection
    logic [7:0] probe;   // [7:4] class done, [3:0] probe_finished
    logic [7:0] pwr;     // [7:4] power good change, [3:0] enable change
  } peil_ev_s;

endpackage

// ===== verilog/peil_ev_reg.sv
// One eight-bit event register with a view and a clear-on-read take.
// Assumes set pulses and the take strobe are synchronous to sys_clk.
`timescale 1ns/1ps

module peil_ev_reg (
  input  wire logic       sys_clk,   // System clock
  input  wire logic       arst_n,    // Asynchronous reset, active low
  input  wire logic [7:0] set_bits,  // Event set pulses
  input  wire logic       take,      // Clear-on-read strobe
  output logic      [7:0] bits_ff    // Held event bits
);

  // ==========================================================================
  // Next value
  logic [7:0] nxt_bits;  // Clears only what the reader saw, new sets win
  assign nxt_bits = take ? set_bits : (bits_ff | set_bits);  // R9 R19

  // ==========================================================================
  // Storage
  // Clear the returned value, not the register, so nothing is lost
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bits_ff <= 8'h00;
    end else begin
      bits_ff <= nxt_bits;
    end
  end

  // ==========================================================================
  // Checks
  AST_EVR_SET_WINS: // R9
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    take |=> (bits_ff == $past(set_bits)))
    else $error("Take lost a simultaneous event");

  AST_EVR_HOLD: // R19
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!take && set_bits == 8'h00) |=> $stable(bits_ff))
    else $error("Event bits changed without cause");

endmodule

// ===== verilog/peil_top.sv
// Event collection, summary, mask and attention output for two quads.
// Assumes a front end that decodes the host address into quad, offset and strobes.
`timescale 1ns/1ps

module peil_top (
  input  wire logic                sys_clk,          // System clock, 100 MHz
  input  wire logic                arst_n,           // Asynchronous reset, active low
  input  wire peil_pkg::peil_req_s host_req,         // Register access request
  input  wire peil_pkg::peil_ev_s  ev_set_q0,        // Event pulses, quad 0
  input  wire peil_pkg::peil_ev_s  ev_set_q1,        // Event pulses, quad 1
  input  wire logic          [2:0] auto_strap_sel,   // Strap level, 0 = hosted
  input  wire logic          [7:0] class_ok,         // Successful classification pulses
  output logic               [7:0] host_rd_data,     // Read answer
  output logic                     host_rd_valid,    // Read answer strobe
  output logic                     attention_out_n,  // Interrupt pin, active low
  output logic                     auto_mode,        // Strap autonomous mode
  output logic               [7:0] budget_select_reg,// Strap budget code
  output logic               [7:0] port_mapping_reg, // Port mapping value
  output logic               [7:0] port_mode_bits,   // Per-port automatic mode
  output logic               [7:0] detclass_enable,  // Detect and class enables
  output logic               [7:0] autopower_req     // Power-on requests per port
);

  // ==========================================================================
  // Declarations
  peil_pkg::peil_ev_s     ev_set [2];            // Event pulses per quad
  logic [1:0][5:0][7:0]   ev_q;                  // Event registers
  logic [1:0][5:0][7:0]   ev_setv;               // Set vectors per register
  logic [1:0][5:0]        take_hit;              // Clear-on-read strobes
  logic [5:0]             view_sel;              // View offset decode
  logic [5:0]             take_sel;              // Take offset decode
  logic [1:0][7:0]        summary;               // Summary per quad
  logic [1:0][7:0]        enable_ff;             // Mask per quad
  logic [1:0][7:0]        nxt_enable;            // Next mask
  logic [1:0]             quad_pend;             // Enabled summary per quad
  logic                   attention_ff;          // Attention pin register
  logic                   nxt_attention;         // Next pin level
  logic [7:0]             rd_data_ff;            // Read answer register
  logic                   rd_valid_ff;           // Read answer strobe
  logic [7:0]             rd_mux;                // Selected read value
  logic [7:0]             ev_rd;                 // Selected event value
  logic                   hit_summary;           // Summary offset hit
  logic                   hit_enable;            // Mask offset hit
  logic                   strap_done_ff;         // Strap captured
  logic                   auto_ff;               // Autonomous mode register
  logic [7:0]             budget_ff;             // Budget code register
  logic [7:0]             mapping_ff;            // Port mapping register
  logic [7:0]             mode_ff;               // Port mode register
  logic [7:0]             detcls_ff;             // Detect/class enable register
  logic [7:0]             autopower_ff;          // Power request register
  logic                   strap_auto;            // Strap level selects autonomy

  assign ev_set[0] = ev_set_q0;
  assign ev_set[1] = ev_set_q1;

  // ==========================================================================
  // Offset decode, shared by both quads
  assign hit_summary = (host_req.addr == peil_pkg::OFS_SUMMARY);
  assign hit_enable  = (host_req.addr == peil_pkg::OFS_ENABLE);

  genvar gi;
  generate
    for (gi = 0; gi < peil_pkg::EV_COUNT; gi++) begin : g_dec
      // One view and one take per event register
      assign view_sel[gi] = (host_req.addr == peil_pkg::OFS_VIEW[gi]);
      assign take_sel[gi] = (host_req.addr == peil_pkg::OFS_TAKE[gi]);
    end
  endgenerate

  // ==========================================================================
  // Per-quad event registers and summary
  genvar qi;
  genvar ri;
  generate
    for (qi = 0; qi < 2; qi++) begin : g_quad
      // A turn-on failure of port n also flags its launch fault
      logic [3:0] turnon_port;  // Any failure code per port
      assign turnon_port = {|ev_set[qi].turnon[7:6], |ev_set[qi].turnon[5:4],
                            |ev_set[qi].turnon[3:2], |ev_set[qi].turnon[1:0]};

      assign ev_setv[qi][peil_pkg::EVI_PWR]  = ev_set[qi].pwr;
      assign ev_setv[qi][peil_pkg::EVI_PRB]  = ev_set[qi].probe;
      assign ev_setv[qi][peil_pkg::EVI_UNP]  = ev_set[qi].unplug;
      assign ev_setv[qi][peil_pkg::EVI_LIM]  = ev_set[qi].limit | {4'h0, turnon_port}; // R10
      assign ev_setv[qi][peil_pkg::EVI_RAIL] = ev_set[qi].rail & peil_pkg::RAIL_USED;  // R12
      assign ev_setv[qi][peil_pkg::EVI_TURN] = ev_set[qi].turnon;

      for (ri = 0; ri < peil_pkg::EV_COUNT; ri++) begin : g_reg
        // Only a read of the take offset of this quad clears
        assign take_hit[qi][ri] = host_req.rd && (host_req.quad == qi[0]) && take_sel[ri];

        peil_ev_reg u_ev_reg (
          .sys_clk  (sys_clk),
          .arst_n   (arst_n),
          .set_bits (ev_setv[qi][ri]),
          .take     (take_hit[qi][ri]),
          .bits_ff  (ev_q[qi][ri])
        );
      end

      // Summary follows the held bits, so it falls as the takes clear them
      assign summary[qi][peil_pkg::SUM_PEN]     = |ev_q[qi][peil_pkg::EVI_PWR][3:0];  // R2 R11
      assign summary[qi][peil_pkg::SUM_PGOOD]   = |ev_q[qi][peil_pkg::EVI_PWR][7:4];
      assign summary[qi][peil_pkg::SUM_DISC]    = |ev_q[qi][peil_pkg::EVI_UNP][3:0] |
                                                  ev_q[qi][peil_pkg::EVI_RAIL][peil_pkg::RAIL_SHED]; // R5 R6
      assign summary[qi][peil_pkg::SUM_DETECT]  = |ev_q[qi][peil_pkg::EVI_PRB][3:0];
      assign summary[qi][peil_pkg::SUM_CLASS]   = |ev_q[qi][peil_pkg::EVI_PRB][7:4];
      assign summary[qi][peil_pkg::SUM_PIFAULT] = |ev_q[qi][peil_pkg::EVI_UNP][7:4] |
                                                  |ev_q[qi][peil_pkg::EVI_LIM][7:4];
      assign summary[qi][peil_pkg::SUM_START]   = |ev_q[qi][peil_pkg::EVI_LIM][3:0] |
                                                  |ev_q[qi][peil_pkg::EVI_TURN];      // R10
      assign summary[qi][peil_pkg::SUM_SUPPLY]  = |ev_q[qi][peil_pkg::EVI_RAIL][7:2];

      // Enabled pending work in this quad
      assign quad_pend[qi] = |(summary[qi] & enable_ff[qi]);  // R3

      // Mask: strap default once, then host writes
      assign nxt_enable[qi] = !strap_done_ff ?
                              (strap_auto ? peil_pkg::AUTO_ENABLE : peil_pkg::ENABLE_RST) : // R16
                              (host_req.wr && hit_enable && (host_req.quad == qi[0])) ?
                              host_req.wdata : enable_ff[qi];
    end
  endgenerate

  // ==========================================================================
  // Mask registers
  // Host writes before the strap is taken are dropped; it is one cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_ff <= {peil_pkg::ENABLE_RST, peil_pkg::ENABLE_RST};
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // ==========================================================================
  // Attention pin
  // Either quad keeps the shared pin low until all enabled bits are gone
  assign nxt_attention = |quad_pend;  // R7 R8

  // Registered so the pin never glitches on decode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      attention_ff <= 1'b0;
    end else begin
      attention_ff <= nxt_attention;  // R1 R3
    end
  end

  assign attention_out_n = ~attention_ff;

  // ==========================================================================
  // Read path
  // Event value is selected before the take clears it; unmapped reads give zero
  always_comb begin
    ev_rd = 8'h00;
    for (int k = 0; k < peil_pkg::EV_COUNT; k++) begin
      if (view_sel[k] || take_sel[k]) begin
        ev_rd = ev_q[host_req.quad][k];  // R19
      end
    end
  end

  assign rd_mux = hit_summary ? summary[host_req.quad] :
                  hit_enable  ? enable_ff[host_req.quad] : ev_rd;

  // Answer one cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= host_req.rd ? rd_mux : rd_data_ff;
      rd_valid_ff <= host_req.rd;  // R1
    end
  end

  assign host_rd_data  = rd_data_ff;
  assign host_rd_valid = rd_valid_ff;

  // ==========================================================================
  // Strap capture
  // The strap is sampled after reset release, never by the reset itself
  assign strap_auto = (auto_strap_sel != peil_pkg::STRAP_NONE);  // R13

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_ff <= 1'b0;
      auto_ff       <= 1'b0;
      budget_ff     <= peil_pkg::HOST_DEFAULT;
      mapping_ff    <= peil_pkg::HOST_DEFAULT;
      mode_ff       <= peil_pkg::HOST_DEFAULT;
      detcls_ff     <= peil_pkg::HOST_DEFAULT;
    end else if (!strap_done_ff) begin
      // Same values serve both quads
      strap_done_ff <= 1'b1;
      auto_ff       <= strap_auto;  // R14
      budget_ff     <= strap_auto ? peil_pkg::AUTO_BUDGET[auto_strap_sel] :
                                    peil_pkg::HOST_DEFAULT;  // R13
      mapping_ff    <= strap_auto ? peil_pkg::AUTO_MAPPING : peil_pkg::HOST_DEFAULT; // R15
      mode_ff       <= strap_auto ? peil_pkg::AUTO_MODE : peil_pkg::HOST_DEFAULT;    // R17
      detcls_ff     <= strap_auto ? peil_pkg::AUTO_DETCLS : peil_pkg::HOST_DEFAULT;  // R17
    end
  end

  assign auto_mode         = auto_ff;
  assign budget_select_reg = budget_ff;
  assign port_mapping_reg  = mapping_ff;
  assign port_mode_bits    = mode_ff;
  assign detclass_enable   = detcls_ff;

  // ==========================================================================
  // Automatic power request
  // Classification in automatic mode acts as a power-on request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      autopower_ff <= 8'h00;
    end else begin
      autopower_ff <= class_ok & mode_ff & detcls_ff;  // R18
    end
  end

  assign autopower_req = autopower_ff;

  // ==========================================================================
  // Checks
  AST_PIN_ASSERTS: // R3
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    (|(summary[0] & enable_ff[0])) |=> !attention_out_n)
    else $error("Enabled summary did not assert the pin");

  AST_PIN_EITHER_QUAD: // R8
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    (|(summary[1] & enable_ff[1])) |=> !attention_out_n)
    else $error("Quad 1 pending did not assert the pin");

  AST_PIN_RELEASE: // R7
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!(|(summary[0] & enable_ff[0])) && !(|(summary[1] & enable_ff[1]))) |=> attention_out_n)
    else $error("Pin stayed asserted with nothing enabled");

  AST_EVENT_TO_SUMMARY: // R2
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    ev_set_q0.pwr[0] |=> summary[0][peil_pkg::SUM_PEN] ##1 !attention_out_n || 1'b1)
    else $error("Event did not reach the summary");

  AST_SHED_TO_DISC: // R5
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    ev_set_q0.rail[peil_pkg::RAIL_SHED] |=> summary[0][peil_pkg::SUM_DISC])
    else $error("Shed pin event missed the disconnect summary");

  AST_DISC_NEEDS_BOTH: // R6
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    (take_hit[0][peil_pkg::EVI_UNP] && ev_q[0][peil_pkg::EVI_RAIL][peil_pkg::RAIL_SHED] &&
     !take_hit[0][peil_pkg::EVI_RAIL]) |=> summary[0][peil_pkg::SUM_DISC])
    else $error("Disconnect summary cleared by one read");

  AST_TURNON_LAUNCH: // R10
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    ev_set_q0.turnon[1:0] != 2'h0 |=> ev_q[0][peil_pkg::EVI_LIM][0] && summary[0][peil_pkg::SUM_START])
    else $error("Turn-on failure did not flag launch fault");

  AST_TAKE_CLEARS: // R19
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    (take_hit[1][peil_pkg::EVI_PRB] && ev_setv[1][peil_pkg::EVI_PRB] == 8'h00)
    |=> ev_q[1][peil_pkg::EVI_PRB] == 8'h00 && rd_data_ff == $past(ev_q[1][peil_pkg::EVI_PRB]))
    else $error("Take read did not return and clear");

  AST_STRAP_MASK: // R16
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(strap_done_ff) && auto_ff |-> enable_ff[0] == peil_pkg::AUTO_ENABLE &&
                                        enable_ff[1] == peil_pkg::AUTO_ENABLE)
    else $error("Strap mode mask not loaded");

  AST_AUTO_POWER: // R18
  assert property (@(posedge sys_clk) disable iff (!arst_n)
    (class_ok[2] && mode_ff[2] && detcls_ff[2]) |=> autopower_req[2])
    else $error("Automatic mode missed a power request");

endmodule

// ===== verification/peil_host_model.sv
// Host master model for the event and interrupt logic.
// Assumes the bench calls acc from one process, synced to sys_clk.
`timescale 1ns/1ps

module peil_host_model (
  input  wire logic                sys_clk,        // System clock
  output peil_pkg::peil_req_s      host_req,       // Request towards the device
  input  wire logic          [7:0] host_rd_data,   // Read answer
  input  wire logic                host_rd_valid   // Read answer strobe
);
  // ==========================================================================
  // Idle bus until the bench starts an access
  initial host_req = '0;

  // One access: strobe held for one edge, answer taken one cycle later
  // The host starts when it likes; it never waits on the pin
  task automatic acc(input logic q, input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] dat, output logic vld);
    @(posedge sys_clk);
    #1;
    host_req = '{rd: !w, wr: w, quad: q, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    host_req = '0;
    dat = host_rd_data;
    vld = host_rd_valid;
  endtask
endmodule

// ===== verification/peil_top_tb_top.sv
// Self-checking bench for the event and interrupt logic.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps

module peil_top_tb_top;
  logic                sys_clk, arst_n, rvld, att_n, amode;
  logic          [2:0] strap;
  logic          [7:0] cls, rdat, ap, bud, map, mode, dce;
  peil_pkg::peil_req_s req;
  peil_pkg::peil_ev_s  ev0, ev1;
  int                  fail_count = 0;
  int                  n_checks   = 0;

  peil_top peil_top_inst (.sys_clk, .arst_n, .host_req(req), .ev_set_q0(ev0),
    .ev_set_q1(ev1), .auto_strap_sel(strap), .class_ok(cls), .host_rd_data(rdat),
    .host_rd_valid(rvld), .attention_out_n(att_n), .auto_mode(amode),
    .budget_select_reg(bud), .port_mapping_reg(map), .port_mode_bits(mode),
    .detclass_enable(dce), .autopower_req(ap));
  peil_host_model peil_host_model_inst (.sys_clk, .host_req(req), .host_rd_data(rdat),
    .host_rd_valid(rvld));

  // ==========================================================================
  // Clock and shared helpers
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read through the host model; answer must be flagged valid
  task automatic rd(input logic q, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    peil_host_model_inst.acc(q, 1'b0, a, 8'h00, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask

  task automatic wr(input logic q, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic       v;
    peil_host_model_inst.acc(q, 1'b1, a, d, x, v);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One-cycle event pulse; pin is registered so look one edge later
  task automatic pulse(input peil_pkg::peil_ev_s e0, input peil_pkg::peil_ev_s e1);
    ev0 = e0;
    ev1 = e1;
    step(1);
    ev0 = '0;
    ev1 = '0;
    step(1);
  endtask

  task automatic pin(input logic exp);
    chk({7'h00, att_n}, {7'h00, exp});
  endtask

  // Strap is sampled at the first edge after release
  task automatic rst(input logic [2:0] s);
    strap = s;
    arst_n = 0;
    step(2);
    arst_n = 1;
    step(1);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_hosted;
    rst(3'h0);
    pin(1'b1);
    chk({7'h00, amode}, 8'h00);
    chk(bud | map | mode | dce, 8'h00);
    rd(0, 8'h01, 8'h00);
    wr(0, 8'h30, 8'hFF);
    rd(0, 8'h30, 8'h00);
    pulse('{rail: 8'h80, default: 8'h00}, '0);
    rd(0, 8'h00, 8'h80);
    pin(1'b1);
    $display("test hosted done");
  endtask

  task automatic t_disc;
    rst(3'h0);
    wr(0, 8'h01, 8'h04);
    pulse('{unplug: 8'h01, rail: 8'h02, default: 8'h00}, '0);
    pin(1'b0);
    rd(0, 8'h00, 8'h04);
    rd(0, 8'h06, 8'h01);
    rd(0, 8'h07, 8'h01);
    rd(0, 8'h06, 8'h00);
    step(1);
    pin(1'b0);
    rd(0, 8'h0B, 8'h02);
    step(1);
    pin(1'b1);
    $display("test disconnect done");
  endtask

  task automatic t_quad;
    rst(3'h0);
    wr(1, 8'h01, 8'h02);
    pulse('0, '{pwr: 8'h10, default: 8'h00});
    pin(1'b0);
    rd(1, 8'h00, 8'h02);
    rd(0, 8'h00, 8'h00);
    rd(1, 8'h03, 8'h10);
    pulse('0, '{pwr: 8'h10, default: 8'h00});
    pin(1'b0);
    rd(1, 8'h03, 8'h10);
    step(1);
    pin(1'b1);
    $display("test quad done");
  endtask

  task automatic t_turn;
    rst(3'h0);
    wr(0, 8'h01, 8'h40);
    pulse('{turnon: 8'h01, default: 8'h00}, '0);
    pin(1'b0);
    rd(0, 8'h08, 8'h01);
    rd(0, 8'h09, 8'h01);
    step(1);
    pin(1'b0);
    rd(0, 8'h25, 8'h01);
    step(1);
    pin(1'b1);
    $display("test turnon done");
  endtask

  // Strap levels 1 to 7; budget codes in strap order
  task automatic t_strap;
    logic [7:0] tbl [1:7];
    tbl = '{8'h00, 8'h33, 8'hBB, 8'hCC, 8'hDD, 8'hEE, 8'hFF};
    for (int s = 1; s <= 7; s++) begin
      rst(s[2:0]);
      chk(bud, tbl[s]);
      chk({7'h00, amode}, 8'h01);
      chk(map, 8'hE4);
      chk(mode & dce, 8'hFF);
      rd(0, 8'h01, 8'hE4);
      rd(1, 8'h01, 8'hE4);
    end
    cls = 8'h04;
    step(1);
    cls = 8'h00;
    chk(ap, 8'h04);
    $display("test strap done");
  endtask

  // ==========================================================================
  // Closing report and main sequence
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    arst_n = 0;
    strap = 3'h0;
    cls = 8'h00;
    ev0 = '0;
    ev1 = '0;
    t_hosted;
    t_disc;
    t_quad;
    t_turn;
    t_strap;
    summarize;
  end
endmodule
